// ### rtl/sdss_pkg.sv
package sdss_pkg;
   localparam int CODE_W = 8;
   localparam int CODE_MSB = CODE_W - 1;
   localparam int CNT_W = 8;
   localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
   localparam logic [CNT_W-1:0] BITS_NONE = 8'h00;
   localparam logic [CNT_W-1:0] BYTE_MASK = 8'h07;

   // Core clock period and the timing figures of the serial port.
   localparam int CLK_PERIOD_PS = 8000;
   localparam int SETTLE_US = 50;
   localparam int SETTLE_CYC = (SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int RELEASE_NS = 50;
   localparam int RELEASE_CYC = (RELEASE_NS * 1000) / CLK_PERIOD_PS;
   localparam int SETTLE_W = 16;
   localparam logic [SETTLE_W-1:0] SETTLE_RST = 16'h0000;
   localparam logic [SETTLE_W-1:0] SETTLE_ONE = 16'h0001;

   typedef logic [CODE_W-1:0] sdss_code_type;

   typedef enum logic [2:0] {
      SDSS_SETTLED = 3'h1,
      SDSS_WINDOW = 3'h2,
      SDSS_SETTLING = 3'h4
   } sdss_state_type;

   // Status seen by the delay path and the system around it.
   typedef struct packed {
      logic window;
      logic load;
      logic settled;
      logic whole;
      logic [CNT_W-1:0] bits_last;
   } sdss_status_type;

   // State held in the serial clock domain.
   typedef struct packed {
      sdss_code_type shift;
      logic [CNT_W-1:0] total;
   } sdss_link_type;

   typedef struct packed {
      logic meta;
      logic stable;
   } sdss_sync_type;
endpackage

// ### rtl/sdss_sync.sv
`timescale 1ns/100ps
module sdss_sync (
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // Asynchronous level and its synchronised copy.
   input wire logic async_i,
   output logic sync_o
);
   import sdss_pkg::*;

   sdss_sync_type r;
   sdss_sync_type r_nxt;

   always_comb begin
      r_nxt = r;
      if (ce_i) begin
         r_nxt.meta = async_i;
         r_nxt.stable = r.meta;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign sync_o = r.stable;
endmodule

// ### rtl/sdss_shifter.sv
`timescale 1ns/100ps
module sdss_shifter #(
   parameter int SETTLE_CYCLES = sdss_pkg::SETTLE_CYC
) (
   // Core clock, reset and clock enable.
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic ce_i,
   // Three-wire serial port.
   input wire logic sclk_i,
   input wire logic en_i,
   input wire logic d_i,
   output logic q_o,
   output logic q_oe_o,
   // Active delay code and status.
   output sdss_pkg::sdss_code_type delay_code_o,
   output sdss_pkg::sdss_status_type status_o
);
   import sdss_pkg::*;

   // Serial clock domain. Enable and data are part of the link and carry setup to the
   // serial clock, so they are sampled directly on its rising edge.
   sdss_link_type link_r;
   sdss_link_type link_nxt;

   always_comb begin
      link_nxt = link_r;
      if (en_i) begin
         link_nxt.shift = {link_r.shift[CODE_MSB-1:0], d_i};
         link_nxt.total = link_r.total + CNT_ONE;
      end
   end

   always_ff @(posedge sclk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link_r <= '{shift: CODE_RST, total: CNT_RST};
      end else begin
         link_r <= link_nxt;
      end
   end

   // The bit leaving the register is the top bit, presented until the next rising edge.
   assign q_o = link_r.shift[CODE_MSB];

   // Core clock domain.
   logic en_s;

   sdss_sync u_en_sync (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .ce_i(ce_i),
      .async_i(en_i),
      .sync_o(en_s)
   );

   typedef struct packed {
      logic en_d;
      logic oe;
      sdss_code_type code;
      logic [CNT_W-1:0] prev_total;
      logic [SETTLE_W-1:0] settle_cnt;
      sdss_state_type state;
      sdss_status_type status;
   } sdss_core_type;

   sdss_core_type r;
   sdss_core_type r_nxt;
   logic en_fall;
   logic en_rise;
   logic [CNT_W-1:0] bits_in_window;

   always_comb begin
      en_fall = r.en_d & ~en_s;
      en_rise = ~r.en_d & en_s;
      // The serial register and bit total stand still while the window is low, and the
      // window stays low far longer than the synchroniser delay, so both are read as
      // quasi-static words once the closing edge has crossed.
      bits_in_window = link_r.total - r.prev_total;
      r_nxt = r;
      if (ce_i) begin
         // The load pulse is part of the frozen state, so it only clears while enabled.
         r_nxt.status.load = 1'b0;
         r_nxt.en_d = en_s;
         // Two sync stages plus this flop keep the release well inside its limit.
         r_nxt.oe = en_s;
         r_nxt.status.window = en_s;
         if (en_fall) begin
            // Any of the 256 codes is taken as it stands, with no range check.
            r_nxt.code = link_r.shift;
            r_nxt.status.load = 1'b1;
            r_nxt.prev_total = link_r.total;
            r_nxt.status.bits_last = bits_in_window;
            r_nxt.status.whole = (bits_in_window != BITS_NONE) &&
               ((bits_in_window & BYTE_MASK) == BITS_NONE);
         end
         unique case (r.state)
            SDSS_SETTLED: begin
               if (en_rise) begin
                  r_nxt.state = SDSS_WINDOW;
                  r_nxt.status.settled = 1'b0;
               end
            end
            SDSS_WINDOW: begin
               if (en_fall) begin
                  r_nxt.state = SDSS_SETTLING;
                  r_nxt.settle_cnt = SETTLE_RST;
               end
            end
            SDSS_SETTLING: begin
               if (en_rise) begin
                  r_nxt.state = SDSS_WINDOW;
               end else if (r.settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
                  r_nxt.state = SDSS_SETTLED;
                  r_nxt.status.settled = 1'b1;
               end else begin
                  r_nxt.settle_cnt = r.settle_cnt + SETTLE_ONE;
               end
            end
            default: begin
               r_nxt.state = SDSS_SETTLED;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         r <= '{en_d: 1'b0, oe: 1'b0, code: CODE_RST, prev_total: CNT_RST,
                settle_cnt: SETTLE_RST, state: SDSS_SETTLED,
                status: '{window: 1'b0, load: 1'b0, settled: 1'b1, whole: 1'b0,
                          bits_last: BITS_NONE}};
      end else begin
         r <= r_nxt;
      end
   end

   assign q_oe_o = r.oe;
   assign delay_code_o = r.code;
   assign status_o = r.status;
endmodule

// ### verif/sdss_shifter_props.sv
`timescale 1ns/100ps
module sdss_shifter_props (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic en_i,
   input wire logic q_oe_o,
   input wire sdss_pkg::sdss_code_type delay_code_o,
   input wire sdss_pkg::sdss_status_type status_o
);
   import sdss_pkg::*;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_open; $rose(en_i); endsequence
   sequence s_close; $fell(en_i); endsequence
   sequence s_idle; !en_i [*8]; endsequence
   chk_close_loads: assert property (s_close |-> ##[1:6] status_o.load) else $error("no load");
   chk_load_single: assert property (status_o.load |=> !status_o.load) else $error("long load");
   chk_code_held: assert property (!status_o.load |-> $stable(delay_code_o)) else $error("code moved");
   chk_oe_on: assert property (s_open |-> ##[1:6] q_oe_o) else $error("q not driven");
   chk_oe_off: assert property (s_close |-> ##[1:6] !q_oe_o) else $error("q not released");
   chk_oe_idle: assert property (s_idle |-> !q_oe_o) else $error("q driven idle");
   chk_idle_quiet: assert property (s_idle |-> !status_o.load) else $error("idle load");
   chk_whole_count: assert property (status_o.whole |-> status_o.bits_last[2:0] == 3'h0) else $error("whole");
   chk_load_unsettled: assert property (status_o.load |-> !status_o.settled) else $error("settled");
endmodule

// ### verif/sdss_host.sv
`timescale 1ns/100ps
module sdss_host (
   output logic sclk_o,
   output logic en_o,
   output logic d_o,
   input wire logic q_i
);
   logic [23:0] rd;
   initial begin
      sclk_o = 1'b0;
      en_o = 1'b0;
      d_o = 1'b0;
      rd = 24'h000000;
   end
   // The serial clock runs n cycles whether or not the window is opened; released data shows the inverse.
   task xfer(input logic [23:0] v, input int n, input bit rb, input bit ena);
      en_o = ena;
      for (int i = 0; i < n; i++) begin
         rd = {rd[22:0], q_i};
         d_o = rb ? q_i : v[n-1-i];
         #24 sclk_o = 1'b1;
         #24 sclk_o = 1'b0;
      end
      #30 en_o = 1'b0;
      d_o = ~d_o;
      #60;
   endtask
endmodule

// ### verif/test_serial_delay_setting_shifter.sv
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; $display("[FAIL] %0t %h /= %h", $time, a, b); end end
module test_serial_delay_setting_shifter;
   import sdss_pkg::*;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic ce_i = 1'b1;
   wire sclk, en, d;
   logic q, q_oe;
   sdss_code_type code, cur, ex;
   sdss_status_type st;
   int mismatches = 0;
   int checks_done = 0;
   int seed = 34236;
   always #4 clk_i = ~clk_i;
   sdss_shifter #(.SETTLE_CYCLES(20)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .sclk_i(sclk),
      .en_i(en), .d_i(d), .q_o(q), .q_oe_o(q_oe), .delay_code_o(code), .status_o(st));
   sdss_host host (.sclk_o(sclk), .en_o(en), .d_o(d), .q_i(q));
   task finish_test;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic sdss_code_type model(sdss_code_type r, logic [23:0] v, int n, bit rb);
      for (int i = 0; i < n; i++)
         r = {r[6:0], rb ? r[7] : v[n-1-i]};
      return r;
   endfunction
   task op(input logic [23:0] v, input int n, input bit rb, input bit ena);
      ex = ena ? model(cur, v, n, rb) : cur;
      host.xfer(v, n, rb, ena);
      `CHK(st.settled, !ena)
      for (int k = 0; k < 40 && st.settled !== 1'b1; k++) @(posedge clk_i);
      #1;
      `CHK(code, ex)
      `CHK(st.window, 1'b0)
      `CHK(q_oe, 1'b0)
      if (ena) begin
         `CHK(st.bits_last, 8'(n))
         `CHK(st.whole, n % 8 == 0)
      end
      if (ena && n >= 8) `CHK(8'(host.rd >> (n - 8)), cur)
      cur = ex;
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      #1;
      `CHK(code, 8'h00)
      `CHK(q_oe, 1'b0)
      cur = 8'h00;
      for (int i = 0; i < 8; i++)
         op(i == 0 ? 24'hFF : i == 1 ? 24'h00 : $random(seed), 8, 0, 1);
      op(24'h0, 8, 1, 1);
      op(24'h3, 4, 0, 1);
      op($random(seed), 16, 0, 1);
      op($random(seed), 24, 1, 1);
      op($random(seed), 8, 0, 0);
      @(posedge clk_i);
      ce_i <= 1'b0;
      repeat (10) @(posedge clk_i);
      `CHK(code, cur)
      `CHK(st.settled, 1'b1)
      ce_i <= 1'b1;
      #1;
      op($random(seed), 8, 0, 1);
      finish_test;
   end
   initial begin
      #100000;
      mismatches++;
      finish_test;
   end
endmodule
bind sdss_shifter sdss_shifter_props chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .en_i(en_i), .q_oe_o(q_oe_o),
   .delay_code_o(delay_code_o), .status_o(status_o));
